// ### cdsk_socket.sv
// one card socket: status sensing and strobe sequencing
`timescale 1ns/100ps
// Function
// - second low, first high means weak battery
// - first low means dead battery, data lost
// - audio only in io mode, sockets merged
// - host audio is xor of both sockets
// - both detect lines low means card present
// - even bytes first enable, odd bytes second
// - io read strobe during host io reads
// - io read strobe for dma card to host
// - io write strobe during host io writes
// - io write strobe for dma host to card
// - output enable low during memory reads
// - output enable is terminal count, dma writes
// - wait input holds off cycle completion
// - independent signal set per socket
module cdsk_socket #(
    parameter int CNT_W = cdsk_pkg::CDSK_CNT_W
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // socket mode
    input wire logic IO_MODE_I,
    input wire logic DMA_MODE_I,
    // host request port
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire cdsk_pkg::cdsk_cyc_t REQ_KIND_I,
    input wire logic REQ_ADDR0_I,
    input wire logic REQ_WIDE_I,
    input wire logic REQ_LAST_I,
    output logic DONE_O,
    // card inputs, active low where named so
    input wire logic CARD_PRESENT_A_N_I,
    input wire logic CARD_PRESENT_B_N_I,
    input wire logic BATTERY_DETECT_A_I,
    input wire logic BATTERY_DETECT_B_I,
    input wire logic CARD_AUDIO_IN_I,
    input wire logic INPUT_ACKNOWLEDGE_N_I,
    input wire logic WAIT_N_I,
    // card strobes, active low
    output logic EVEN_BYTE_ENABLE_N_O,
    output logic ODD_BYTE_ENABLE_N_O,
    output logic IO_READ_STROBE_N_O,
    output logic IO_WRITE_STROBE_N_O,
    output logic OUTPUT_ENABLE_N_O,
    output logic WRITE_ENABLE_N_O,
    // status to host
    output logic PRESENT_O,
    output cdsk_pkg::cdsk_batt_t BATT_O,
    output logic CARD_STATUS_CHANGE_O,
    output logic RING_INDICATION_O,
    output logic DMA_REQUEST_O,
    output logic IO_ACK_O,
    output logic AUDIO_O
);
    logic cd_a, cd_b, bvd_a, bvd_b, aud, input_acknowledge_n, wait_n;
    cdsk_sync u_cd_a (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .pin_i(CARD_PRESENT_A_N_I),
        .lvl_o(cd_a));
    cdsk_sync u_cd_b (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .pin_i(CARD_PRESENT_B_N_I),
        .lvl_o(cd_b));
    cdsk_sync u_bvd_a (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .pin_i(BATTERY_DETECT_A_I),
        .lvl_o(bvd_a));
    cdsk_sync u_bvd_b (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .pin_i(BATTERY_DETECT_B_I),
        .lvl_o(bvd_b));
    cdsk_sync #(.RST_VAL(1'b0)) u_aud (.clk_i(CLK_SYS_I), .nrst_i(NRST_I),
        .pin_i(CARD_AUDIO_IN_I), .lvl_o(aud));
    cdsk_sync u_inp (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .pin_i(INPUT_ACKNOWLEDGE_N_I),
        .lvl_o(input_acknowledge_n));
    cdsk_sync u_wait (.clk_i(CLK_SYS_I), .nrst_i(NRST_I), .pin_i(WAIT_N_I),
        .lvl_o(wait_n));

    // ------------------------------------------------------------
    // status decode
    // ------------------------------------------------------------
    wire present = !cd_a && !cd_b;
    wire cdsk_pkg::cdsk_batt_t batt = !bvd_a ? cdsk_pkg::CDSK_BATT_DEAD :
        (!bvd_b ? cdsk_pkg::CDSK_BATT_WEAK : cdsk_pkg::CDSK_BATT_GOOD);
    wire io_on = present && IO_MODE_I;
    // shared first battery line reads as status change or ring in io mode with dma mode off
    wire card_status_change = io_on && !bvd_a;
    wire dreq = io_on && DMA_MODE_I && (!bvd_b || !input_acknowledge_n);

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PRESENT_O <= 1'b0;
            BATT_O <= cdsk_pkg::CDSK_BATT_GOOD;
            CARD_STATUS_CHANGE_O <= 1'b0;
            RING_INDICATION_O <= 1'b0;
            DMA_REQUEST_O <= 1'b0;
            AUDIO_O <= 1'b0;
        end else begin
            PRESENT_O <= present;
            BATT_O <= present ? batt : cdsk_pkg::CDSK_BATT_GOOD;
            CARD_STATUS_CHANGE_O <= card_status_change && !DMA_MODE_I;
            RING_INDICATION_O <= card_status_change && !DMA_MODE_I;
            DMA_REQUEST_O <= dreq;
            AUDIO_O <= io_on && aud;
        end
    end

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    cdsk_pkg::cdsk_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    cdsk_pkg::cdsk_cyc_t kind_q;
    logic a0_q, wide_q, last_q, ack_q;

    function automatic logic [CNT_W-1:0] cyc_load(input int n);
        cyc_load = CNT_W'(n - 1);
    endfunction

    wire cnt_zero = (cnt_q == '0);
    wire stall = !wait_n;
    assign REQ_READY_O = (st_q == cdsk_pkg::CDSK_ST_IDLE) && present;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_zero ? cnt_q : cnt_q - CNT_W'(1);
        unique case (st_q)
            cdsk_pkg::CDSK_ST_IDLE: begin
                if (REQ_VALID_I && REQ_READY_O) begin
                    st_d = cdsk_pkg::CDSK_ST_SETUP;
                    cnt_d = cyc_load(cdsk_pkg::CDSK_SETUP_CYC);
                end
            end
            cdsk_pkg::CDSK_ST_SETUP: if (cnt_zero) begin
                st_d = cdsk_pkg::CDSK_ST_STROBE;
                cnt_d = cyc_load(cdsk_pkg::CDSK_STROBE_CYC);
            end
            cdsk_pkg::CDSK_ST_STROBE: if (cnt_zero && !stall) begin
                st_d = cdsk_pkg::CDSK_ST_HOLD;
                cnt_d = cyc_load(cdsk_pkg::CDSK_HOLD_CYC);
            end
            cdsk_pkg::CDSK_ST_HOLD: if (cnt_zero) begin
                st_d = cdsk_pkg::CDSK_ST_IDLE;
            end
        endcase
        if (!present) begin
            st_d = cdsk_pkg::CDSK_ST_IDLE;
        end
    end

    // state, counter and captured request
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q <= cdsk_pkg::CDSK_ST_IDLE;
            cnt_q <= '0;
            kind_q <= cdsk_pkg::CDSK_CYC_MEM_RD;
            a0_q <= 1'b0;
            wide_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            if (REQ_VALID_I && REQ_READY_O) begin
                kind_q <= REQ_KIND_I;
                a0_q <= REQ_ADDR0_I;
                wide_q <= REQ_WIDE_I;
                last_q <= REQ_LAST_I;
            end
        end
    end

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    wire busy = (st_q != cdsk_pkg::CDSK_ST_IDLE) && present;
    wire strobe = (st_q == cdsk_pkg::CDSK_ST_STROBE) && present;
    wire even_d = busy && (wide_q || !a0_q);
    wire odd_d = busy && (wide_q || a0_q);
    wire io_read_strobe_d = strobe && (kind_q == cdsk_pkg::CDSK_CYC_IO_RD ||
        kind_q == cdsk_pkg::CDSK_CYC_DMA_TO_HOST);
    wire io_write_strobe_d = strobe && (kind_q == cdsk_pkg::CDSK_CYC_IO_WR ||
        kind_q == cdsk_pkg::CDSK_CYC_DMA_TO_CARD);
    // dma write (card to host) flags terminal count on output enable, dma read on write enable
    wire oe_d = strobe && (kind_q == cdsk_pkg::CDSK_CYC_MEM_RD ||
        (kind_q == cdsk_pkg::CDSK_CYC_DMA_TO_HOST && last_q));
    wire we_d = strobe && (kind_q == cdsk_pkg::CDSK_CYC_MEM_WR ||
        (kind_q == cdsk_pkg::CDSK_CYC_DMA_TO_CARD && last_q));
    wire done_d = (st_q == cdsk_pkg::CDSK_ST_HOLD) && cnt_zero && present;

    // registered strobes keep pins glitch free
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            EVEN_BYTE_ENABLE_N_O <= 1'b1;
            ODD_BYTE_ENABLE_N_O <= 1'b1;
            IO_READ_STROBE_N_O <= 1'b1;
            IO_WRITE_STROBE_N_O <= 1'b1;
            OUTPUT_ENABLE_N_O <= 1'b1;
            WRITE_ENABLE_N_O <= 1'b1;
            DONE_O <= 1'b0;
            ack_q <= 1'b0;
            IO_ACK_O <= 1'b0;
        end else begin
            EVEN_BYTE_ENABLE_N_O <= !even_d;
            ODD_BYTE_ENABLE_N_O <= !odd_d;
            IO_READ_STROBE_N_O <= !io_read_strobe_d;
            IO_WRITE_STROBE_N_O <= !io_write_strobe_d;
            OUTPUT_ENABLE_N_O <= !oe_d;
            WRITE_ENABLE_N_O <= !we_d;
            DONE_O <= done_d;
            // acknowledge is only meaningful under a host io read strobe
            if (st_q == cdsk_pkg::CDSK_ST_IDLE) begin
                ack_q <= 1'b0;
            end else if (!IO_READ_STROBE_N_O && kind_q == cdsk_pkg::CDSK_CYC_IO_RD &&
                !input_acknowledge_n) begin
                ack_q <= 1'b1;
            end
            IO_ACK_O <= done_d && ack_q;
        end
    end
endmodule // cdsk_socket

// ### cdsk_pkg.sv
// package of constants and types for the dual-socket card control block
package cdsk_pkg;
    // battery condition codes
    typedef enum logic [1:0] {
        CDSK_BATT_GOOD = 2'b00,
        CDSK_BATT_WEAK = 2'b01,
        CDSK_BATT_DEAD = 2'b10
    } cdsk_batt_t;
    // cycle kinds presented on the host request port
    typedef enum logic [2:0] {
        CDSK_CYC_MEM_RD = 3'b000,
        CDSK_CYC_MEM_WR = 3'b001,
        CDSK_CYC_IO_RD = 3'b010,
        CDSK_CYC_IO_WR = 3'b011,
        CDSK_CYC_DMA_TO_HOST = 3'b100,
        CDSK_CYC_DMA_TO_CARD = 3'b101
    } cdsk_cyc_t;
    // cycle sequencer states
    typedef enum logic [1:0] {
        CDSK_ST_IDLE = 2'b00,
        CDSK_ST_SETUP = 2'b01,
        CDSK_ST_STROBE = 2'b10,
        CDSK_ST_HOLD = 2'b11
    } cdsk_state_t;
    // strobe timing in ns, turned into cycles at the system clock rate
    localparam int CDSK_CLK_NS = 20;
    localparam int CDSK_SETUP_NS = 60;
    localparam int CDSK_STROBE_NS = 300;
    localparam int CDSK_HOLD_NS = 40;
    localparam int CDSK_SETUP_CYC = (CDSK_SETUP_NS + CDSK_CLK_NS - 1) / CDSK_CLK_NS;
    localparam int CDSK_STROBE_CYC = (CDSK_STROBE_NS + CDSK_CLK_NS - 1) / CDSK_CLK_NS;
    localparam int CDSK_HOLD_CYC = (CDSK_HOLD_NS + CDSK_CLK_NS - 1) / CDSK_CLK_NS;
    localparam int CDSK_CNT_W = 5;
    localparam logic [2:0] CDSK_SYNC_RST = 3'h7;
endpackage : cdsk_pkg

// ### cdsk_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cdsk_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // pin and filtered level
    input wire logic pin_i,
    output logic lvl_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // stage one feeds stage two only; level changes once two and three agree
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            lvl_o <= RST_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_o <= s3_q;
            end
        end
    end
endmodule // cdsk_sync

// ### cdsk_top.sv
// two independent sockets with merged host audio
`timescale 1ns/100ps
module cdsk_top (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // per-socket vectors, bit 0 socket a, bit 1 socket b
    input wire logic [1:0] IO_MODE_I,
    input wire logic [1:0] DMA_MODE_I,
    input wire logic [1:0] REQ_VALID_I,
    output logic [1:0] REQ_READY_O,
    input wire cdsk_pkg::cdsk_cyc_t REQ_KIND_A_I,
    input wire cdsk_pkg::cdsk_cyc_t REQ_KIND_B_I,
    input wire logic [1:0] REQ_ADDR0_I,
    input wire logic [1:0] REQ_WIDE_I,
    input wire logic [1:0] REQ_LAST_I,
    output logic [1:0] DONE_O,
    input wire logic [1:0] CARD_PRESENT_A_N_I,
    input wire logic [1:0] CARD_PRESENT_B_N_I,
    input wire logic [1:0] BATTERY_DETECT_A_I,
    input wire logic [1:0] BATTERY_DETECT_B_I,
    input wire logic [1:0] CARD_AUDIO_IN_I,
    input wire logic [1:0] INPUT_ACKNOWLEDGE_N_I,
    input wire logic [1:0] WAIT_N_I,
    output logic [1:0] EVEN_BYTE_ENABLE_N_O,
    output logic [1:0] ODD_BYTE_ENABLE_N_O,
    output logic [1:0] IO_READ_STROBE_N_O,
    output logic [1:0] IO_WRITE_STROBE_N_O,
    output logic [1:0] OUTPUT_ENABLE_N_O,
    output logic [1:0] WRITE_ENABLE_N_O,
    output logic [1:0] PRESENT_O,
    output cdsk_pkg::cdsk_batt_t BATT_A_O,
    output cdsk_pkg::cdsk_batt_t BATT_B_O,
    output logic [1:0] CARD_STATUS_CHANGE_O,
    output logic [1:0] RING_INDICATION_O,
    output logic [1:0] DMA_REQUEST_O,
    output logic [1:0] IO_ACK_O,
    // merged speaker
    output logic HOST_AUDIO_OUT_O
);
    logic [1:0] aud;
    cdsk_pkg::cdsk_batt_t batt [2];
    cdsk_pkg::cdsk_cyc_t kind [2];
    assign kind[0] = REQ_KIND_A_I;
    assign kind[1] = REQ_KIND_B_I;
    assign BATT_A_O = batt[0];
    assign BATT_B_O = batt[1];
    // one full copy per socket
    for (genvar s = 0; s < 2; s++) begin : g_sock
        cdsk_socket u_sock (
            .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
            .IO_MODE_I(IO_MODE_I[s]), .DMA_MODE_I(DMA_MODE_I[s]),
            .REQ_VALID_I(REQ_VALID_I[s]), .REQ_READY_O(REQ_READY_O[s]),
            .REQ_KIND_I(kind[s]), .REQ_ADDR0_I(REQ_ADDR0_I[s]),
            .REQ_WIDE_I(REQ_WIDE_I[s]), .REQ_LAST_I(REQ_LAST_I[s]), .DONE_O(DONE_O[s]),
            .CARD_PRESENT_A_N_I(CARD_PRESENT_A_N_I[s]),
            .CARD_PRESENT_B_N_I(CARD_PRESENT_B_N_I[s]),
            .BATTERY_DETECT_A_I(BATTERY_DETECT_A_I[s]),
            .BATTERY_DETECT_B_I(BATTERY_DETECT_B_I[s]),
            .CARD_AUDIO_IN_I(CARD_AUDIO_IN_I[s]),
            .INPUT_ACKNOWLEDGE_N_I(INPUT_ACKNOWLEDGE_N_I[s]), .WAIT_N_I(WAIT_N_I[s]),
            .EVEN_BYTE_ENABLE_N_O(EVEN_BYTE_ENABLE_N_O[s]),
            .ODD_BYTE_ENABLE_N_O(ODD_BYTE_ENABLE_N_O[s]),
            .IO_READ_STROBE_N_O(IO_READ_STROBE_N_O[s]),
            .IO_WRITE_STROBE_N_O(IO_WRITE_STROBE_N_O[s]),
            .OUTPUT_ENABLE_N_O(OUTPUT_ENABLE_N_O[s]),
            .WRITE_ENABLE_N_O(WRITE_ENABLE_N_O[s]),
            .PRESENT_O(PRESENT_O[s]), .BATT_O(batt[s]),
            .CARD_STATUS_CHANGE_O(CARD_STATUS_CHANGE_O[s]),
            .RING_INDICATION_O(RING_INDICATION_O[s]),
            .DMA_REQUEST_O(DMA_REQUEST_O[s]), .IO_ACK_O(IO_ACK_O[s]), .AUDIO_O(aud[s])
        );
    end
    // registered merge of the gated socket audio
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            HOST_AUDIO_OUT_O <= 1'b0;
        end else begin
            HOST_AUDIO_OUT_O <= aud[0] ^ aud[1];
        end
    end
endmodule // cdsk_top

// ### cdsk_card.sv
// behavioural card seated in one socket, driven by bench controls
`timescale 1ns/100ps
module cdsk_card (
    // clock
    input wire logic clk_i,
    // scenario controls
    input wire logic insert_i,
    input wire logic [1:0] batt_i,
    input wire logic audio_i,
    input wire logic ack_en_i,
    input wire logic stall_i,
    // socket strobes, active low
    input wire logic io_read_strobe_n_i,
    input wire logic strobe_n_i,
    // card pins
    output logic present_a_n_o,
    output logic present_b_n_o,
    output logic batt_a_o,
    output logic batt_b_o,
    output logic audio_o,
    output logic ack_n_o,
    output logic wait_n_o
);
    logic [4:0] cnt_q = 5'h00;
    // strobe age, saturating so a stuck strobe cannot wrap the wait window
    always_ff @(posedge clk_i) begin
        cnt_q <= strobe_n_i ? 5'h00 : (cnt_q < 5'h14 ? cnt_q + 5'h01 : cnt_q);
    end
    // detect lines grounded by the card, socket pull-ups win when empty
    assign present_a_n_o = !insert_i;
    assign present_b_n_o = !insert_i;
    // good battery shows both lines high; status, ring and dma requests share them
    assign batt_a_o = insert_i ? batt_i[1] : 1'b1;
    assign batt_b_o = insert_i ? batt_i[0] : 1'b1;
    assign audio_o = insert_i & audio_i; // pulled down when empty
    assign ack_n_o = !(insert_i && ack_en_i && !io_read_strobe_n_i);
    // slow card: holds wait for the first 20 cycles of any strobe
    assign wait_n_o = !(insert_i && stall_i && !strobe_n_i && cnt_q < 5'h14);
endmodule // cdsk_card

// ### cdsk_chk.sv
// strobe timing checker bound to the top module ports
`timescale 1ns/100ps
module cdsk_chk (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // host request port
    input wire logic [1:0] REQ_VALID_I,
    input wire logic [1:0] REQ_READY_O,
    input wire cdsk_pkg::cdsk_cyc_t REQ_KIND_A_I,
    input wire cdsk_pkg::cdsk_cyc_t REQ_KIND_B_I,
    input wire logic [1:0] REQ_ADDR0_I,
    input wire logic [1:0] REQ_WIDE_I,
    input wire logic [1:0] REQ_LAST_I,
    input wire logic [1:0] DONE_O,
    // card strobes and presence
    input wire logic [1:0] EVEN_BYTE_ENABLE_N_O,
    input wire logic [1:0] ODD_BYTE_ENABLE_N_O,
    input wire logic [1:0] IO_READ_STROBE_N_O,
    input wire logic [1:0] IO_WRITE_STROBE_N_O,
    input wire logic [1:0] OUTPUT_ENABLE_N_O,
    input wire logic [1:0] WRITE_ENABLE_N_O,
    input wire logic [1:0] PRESENT_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    // take strobes and socket a strobe group
    wire logic take_a = REQ_VALID_I[0] & REQ_READY_O[0];
    wire logic take_b = REQ_VALID_I[1] & REQ_READY_O[1];
    wire logic [5:0] strb_a = {EVEN_BYTE_ENABLE_N_O[0], ODD_BYTE_ENABLE_N_O[0],
        IO_READ_STROBE_N_O[0], IO_WRITE_STROBE_N_O[0], OUTPUT_ENABLE_N_O[0], WRITE_ENABLE_N_O[0]};
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    no_card_idle_a: assert property (!PRESENT_O[0] && $past(!PRESENT_O[0]) |-> &strb_a)
        else $error("strobe active with empty socket");
    // registered pins: enables show two samples after the take, strobes five
    even_lane_a: assert property (take_a && !REQ_WIDE_I[0] && !REQ_ADDR0_I[0]
        |-> ##2 !EVEN_BYTE_ENABLE_N_O[0] && ODD_BYTE_ENABLE_N_O[0])
        else $error("even lane wrong");
    odd_lane_a: assert property (take_a && !REQ_WIDE_I[0] && REQ_ADDR0_I[0]
        |-> ##2 EVEN_BYTE_ENABLE_N_O[0] && !ODD_BYTE_ENABLE_N_O[0])
        else $error("odd lane wrong");
    io_read_a: assert property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_IO_RD
        |-> ##5 !IO_READ_STROBE_N_O[0] && IO_WRITE_STROBE_N_O[0]) else $error("io read late");
    io_write_a: assert property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_IO_WR
        |-> ##5 !IO_WRITE_STROBE_N_O[0] && IO_READ_STROBE_N_O[0]) else $error("io write late");
    mem_read_a: assert property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_MEM_RD
        |-> ##5 !OUTPUT_ENABLE_N_O[0] && WRITE_ENABLE_N_O[0]) else $error("mem read late");
    dma_host_a: assert property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_DMA_TO_HOST
        |-> ##5 !IO_READ_STROBE_N_O[0]) else $error("dma to host strobe late");
    dma_card_a: assert property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_DMA_TO_CARD
        |-> ##5 !IO_WRITE_STROBE_N_O[0]) else $error("dma to card strobe late");
    term_count_a: assert property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_DMA_TO_HOST
        && REQ_LAST_I[0] |-> ##[1:21] !OUTPUT_ENABLE_N_O[0]) else $error("no terminal count");
    sock_b_a: assert property (take_b && REQ_KIND_B_I == cdsk_pkg::CDSK_CYC_IO_RD
        |-> ##5 !IO_READ_STROBE_N_O[1] && IO_READ_STROBE_N_O[0]) else $error("socket b read");
    // main scenarios reached
    cover property (take_a && REQ_KIND_A_I == cdsk_pkg::CDSK_CYC_DMA_TO_CARD);
    cover property (DONE_O[0]);
    cover property (take_b);
endmodule // cdsk_chk

bind cdsk_top cdsk_chk chk_u (.CLK_SYS_I, .NRST_I, .REQ_VALID_I, .REQ_READY_O, .REQ_KIND_A_I,
    .REQ_KIND_B_I, .REQ_ADDR0_I, .REQ_WIDE_I, .REQ_LAST_I, .DONE_O, .EVEN_BYTE_ENABLE_N_O,
    .ODD_BYTE_ENABLE_N_O, .IO_READ_STROBE_N_O, .IO_WRITE_STROBE_N_O, .OUTPUT_ENABLE_N_O,
    .WRITE_ENABLE_N_O, .PRESENT_O);

// ### tb_cdsk_top.sv
// self-checking bench for the dual socket card control block
`timescale 1ns/100ps
module tb_cdsk_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] io = 2'h0, dma = 2'h0, valid = 2'h0, a0 = 2'h0, wide = 2'h0, last = 2'h0;
    logic [1:0] ins = 2'h3, la = 2'h3, lb = 2'h3, aud = 2'h0, acken = 2'h0, stall = 2'h0;
    cdsk_pkg::cdsk_cyc_t kind_a = cdsk_pkg::CDSK_CYC_MEM_RD, kind_b = cdsk_pkg::CDSK_CYC_MEM_RD;
    wire logic [1:0] ready, done, pa_n, pb_n, bla, blb, aud_p, ack_n, wait_n, even_n, odd_n;
    wire logic [1:0] io_read_strobe_n, io_write_strobe_n, oe_n, we_n, present, stchg, ring, dreq, ioack;
    wire cdsk_pkg::cdsk_batt_t batt_a, batt_b;
    wire logic haud;
    logic [31:0] rnd = 32'hbac4325f;
    logic [5:0] e, g;
    int n;
    int miscompares = 0;
    int check_count = 0;
    // 50 MHz system clock
    always #10 clk = ~clk;
    cdsk_top dut_u (.CLK_SYS_I(clk), .NRST_I(nrst), .IO_MODE_I(io), .DMA_MODE_I(dma),
        .REQ_VALID_I(valid), .REQ_READY_O(ready), .REQ_KIND_A_I(kind_a), .REQ_KIND_B_I(kind_b),
        .REQ_ADDR0_I(a0), .REQ_WIDE_I(wide), .REQ_LAST_I(last), .DONE_O(done),
        .CARD_PRESENT_A_N_I(pa_n), .CARD_PRESENT_B_N_I(pb_n), .BATTERY_DETECT_A_I(bla),
        .BATTERY_DETECT_B_I(blb), .CARD_AUDIO_IN_I(aud_p), .INPUT_ACKNOWLEDGE_N_I(ack_n),
        .WAIT_N_I(wait_n), .EVEN_BYTE_ENABLE_N_O(even_n), .ODD_BYTE_ENABLE_N_O(odd_n),
        .IO_READ_STROBE_N_O(io_read_strobe_n), .IO_WRITE_STROBE_N_O(io_write_strobe_n), .OUTPUT_ENABLE_N_O(oe_n),
        .WRITE_ENABLE_N_O(we_n), .PRESENT_O(present), .BATT_A_O(batt_a), .BATT_B_O(batt_b),
        .CARD_STATUS_CHANGE_O(stchg), .RING_INDICATION_O(ring), .DMA_REQUEST_O(dreq),
        .IO_ACK_O(ioack), .HOST_AUDIO_OUT_O(haud));
    // one card per socket, each with its own pins
    for (genvar s = 0; s < 2; s++) begin : g_card
        cdsk_card card_u (.clk_i(clk), .insert_i(ins[s]), .batt_i({la[s], lb[s]}),
            .audio_i(aud[s]), .ack_en_i(acken[s]), .stall_i(stall[s]), .io_read_strobe_n_i(io_read_strobe_n[s]),
            .strobe_n_i(io_read_strobe_n[s] & io_write_strobe_n[s] & oe_n[s] & we_n[s]), .present_a_n_o(pa_n[s]),
            .present_b_n_o(pb_n[s]), .batt_a_o(bla[s]), .batt_b_o(blb[s]),
            .audio_o(aud_p[s]), .ack_n_o(ack_n[s]), .wait_n_o(wait_n[s]));
    end
    // ------------------------------------------------------------
    // reference model and helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // first line low wins over second line low
    function automatic logic [1:0] bexp(input logic a, input logic b);
        return !a ? 2'h2 : (!b ? 2'h1 : 2'h0);
    endfunction
    task check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // status levels after the pin synchronisers settle; empty sockets read as pulled up
    task status(input logic [1:0] pa, input logic [1:0] pb);
        repeat (10) @(negedge clk);
        check(8'(present), 8'(ins));
        check(8'(batt_a), 8'(bexp(pa[0], pb[0])));
        check(8'(batt_b), 8'(bexp(pa[1], pb[1])));
        check(8'(stchg), 8'(io & ~dma & ~pa));
        check(8'(ring), 8'(io & ~dma & ~pa));
        check(8'(dreq), 8'(io & dma & ~pb));
        check(8'(haud), 8'(^(aud & ins & io)));
    endtask
    // one cycle on socket s; stl makes the card stretch it, ab pulls the card out midway
    task run(input int s, input cdsk_pkg::cdsk_cyc_t k, input logic p, input logic w,
        input logic stl, input logic ab);
        e = {p & ~w, ~p & ~w, 4'hf};
        case (k)
            cdsk_pkg::CDSK_CYC_MEM_RD: e[1] = 1'b0;
            cdsk_pkg::CDSK_CYC_MEM_WR: e[0] = 1'b0;
            cdsk_pkg::CDSK_CYC_IO_RD: e[3] = 1'b0;
            // dma always marks the last word: output enable to host, write enable to card
            cdsk_pkg::CDSK_CYC_DMA_TO_HOST: e[3:0] = 4'h5;
            cdsk_pkg::CDSK_CYC_DMA_TO_CARD: e[3:0] = 4'ha;
            default: e[2] = 1'b0;
        endcase
        n = 0;
        while (ready[s] !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 60) begin
                check(8'h00, 8'h01);
                print_verdict();
            end
        end
        @(posedge clk);
        io[s] <= k inside {cdsk_pkg::CDSK_CYC_IO_RD, cdsk_pkg::CDSK_CYC_IO_WR};
        dma[s] <= k[2];
        if (s == 1) kind_b <= k;
        else kind_a <= k;
        a0[s] <= p;
        wide[s] <= w;
        last[s] <= k[2];
        stall[s] <= stl;
        @(posedge clk) valid[s] <= 1'b1;
        @(posedge clk) valid[s] <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            g = {even_n[s], odd_n[s], io_read_strobe_n[s], io_write_strobe_n[s], oe_n[s], we_n[s]};
            if (n == 10) check(8'(g), 8'(e));
            if (ab && n == 8) @(posedge clk) ins[s] <= 1'b0;
        end while (done[s] !== 1'b1 && n < 60);
        if (ab) begin
            check(8'(n), 8'd60);
            check({2'h0, g}, 8'h3f);
            status(~ins | la, ~ins | lb);
            @(posedge clk) ins[s] <= 1'b1;
        end else begin
            check(8'(stl ? int'(n > 21) : n), stl ? 8'h01 : 8'h15);
            check(8'(ioack[s]), 8'(k == cdsk_pkg::CDSK_CYC_IO_RD && acken[s]));
        end
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            rnd = lfsr(rnd);
            ins <= {rnd[10], i < 12};
            la <= {rnd[0], i[1]};
            lb <= {rnd[1], i[0]};
            aud <= rnd[3:2];
            io <= rnd[5:4];
            dma <= rnd[7:6];
            @(posedge clk);
            status(~ins | la, ~ins | lb);
        end
        @(posedge clk);
        ins <= 2'h3;
        la <= 2'h3;
        lb <= 2'h3;
        for (int k = 0; k < 6; k++) run(0, cdsk_pkg::cdsk_cyc_t'(k), k[0], k == 1, 1'b0, 1'b0);
        run(0, cdsk_pkg::CDSK_CYC_IO_RD, 1'b0, 1'b0, 1'b1, 1'b0);
        @(posedge clk) acken <= 2'h2;
        run(1, cdsk_pkg::CDSK_CYC_IO_RD, 1'b1, 1'b0, 1'b0, 1'b0);
        run(0, cdsk_pkg::CDSK_CYC_MEM_RD, 1'b0, 1'b1, 1'b0, 1'b1);
        print_verdict();
    end
endmodule // tb_cdsk_top
